// *** itpa_arbiter.v ***
`timescale 1ns/1ps
`include "itpa_defs.vh"
////////////////////////////////////////////////////////////////////////////////
module itpa_arbiter #(
   parameter NSRC = `ITPA_NSRC
) (
   // clock and reset
   input wire mclk,
   input wire reset,
   // register port
   input wire [`ITPA_ADDR_W-1:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // peripheral requests, one pulse or level per source
   input wire [NSRC-1:0] periph_event,
   // external pins, already edge-qualified upstream
   input wire ext_request_0,
   input wire ext_request_1,
   input wire ext_request_2,
   input wire ext_request_3,
   input wire ext_request_4,
   input wire pwm_fault_a,
   input wire pwm_fault_b,
   input wire pwm_period_irq,
   input wire quadrature_encoder_irq,
   input wire low_voltage_detect_irq,
   // trap conditions from the core, bit i is level 8+i
   input wire [7:0] trap_event,
   input wire trap_flushed,
   input wire instr_done,
   input wire vector_invalid,
   // reset causes
   input wire wdt_timeout,
   input wire uninit_ptr,
   input wire illegal_opcode,
   input wire brownout_reset,
   // core side
   input wire irq_ack,
   input wire irq_return,
   output reg irq_req,
   output reg [5:0] irq_vector,
   output reg [3:0] irq_level,
   output wire trap_level_msb,
   output reg device_reset_req,
   output reg [23:0] reset_pc
);

   localparam ST_RUN = 2'b01;
   localparam ST_SERV = 2'b10;

   // decoded external pins into source numbers
   reg [NSRC-1:0] req_in;
   reg [NSRC-1:0] request_flag_regs_r;
   reg [NSRC-1:0] request_enable_regs_r;
   reg [3*NSRC-1:0] source_priority_field_r;
   reg nesting_disable_r;
   reg [3:0] cpu_priority_level_r;
   reg [1:0] state_r;
   reg [7:0] trap_pend_r;
   reg [7:0] trap_act_r;
   reg [2:0] rst_cause_r;
   reg sync1_r, sync2_r;
   reg [5:0] win_src;
   reg [2:0] win_lvl;
   reg win_any;
   reg [2:0] top_trap;
   reg trap_any;
   integer i;
   integer map_i;
   integer arb_i;
   integer rd_i;

   ////////////////////////////////////////////////////////////////////////////
   // count set bits, used for simultaneous trap detection
   function [3:0] popcnt8;
      input [7:0] v;
      integer k;
      begin
         popcnt8 = 4'h0;
         for (k = 0; k < 8; k = k + 1) begin
            popcnt8 = popcnt8 + {3'h0, v[k]};
         end
      end
   endfunction

   // one 16-bit word of a wide vector
   function [15:0] word_of;
      input [3*NSRC-1:0] v;
      input [5:0] w;
      input [5:0] sh;
      integer k;
      begin
         word_of = 16'h0000;
         for (k = 0; k < 16; k = k + 1) begin
            if ({26'h0, w} * 16 + k < 3 * NSRC && k < 16) begin
               word_of[k] = v[{26'h0, w} * 16 + k];
            end
         end
         if (sh != 6'h00) begin
            word_of = 16'h0000;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // map pins onto source slots; reserved slots get no requester
   always @* begin
      req_in = periph_event;
      req_in[`ITPA_SRC_EXT0] = ext_request_0;
      req_in[`ITPA_SRC_EXT1] = ext_request_1;
      req_in[`ITPA_SRC_EXT2] = ext_request_2;
      req_in[`ITPA_SRC_EXT3] = ext_request_3;
      req_in[`ITPA_SRC_EXT4] = ext_request_4;
      req_in[`ITPA_SRC_PWM] = pwm_period_irq;
      req_in[`ITPA_SRC_QEI] = quadrature_encoder_irq;
      req_in[`ITPA_SRC_LVD] = low_voltage_detect_irq;
      req_in[`ITPA_SRC_PWM_FAULT_A] = pwm_fault_a;
      req_in[`ITPA_SRC_PWM_FAULT_B] = pwm_fault_b;
      req_in[`ITPA_SRC_RSVD] = 1'b0;
      for (map_i = `ITPA_SRC_RSVD_LO; map_i < NSRC; map_i = map_i + 1) begin
         req_in[map_i] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // arbitration: highest level, lowest source number on ties
   always @* begin
      win_src = 6'h00;
      win_lvl = 3'h0;
      win_any = 1'b0;
      for (arb_i = 0; arb_i < NSRC; arb_i = arb_i + 1) begin
         if (request_flag_regs_r[arb_i] && request_enable_regs_r[arb_i] &&
             source_priority_field_r[3*arb_i +: 3] != 3'h0 &&
             (!win_any || source_priority_field_r[3*arb_i +: 3] > win_lvl)) begin
            win_any = 1'b1;
            win_lvl = source_priority_field_r[3*arb_i +: 3];
            win_src = arb_i[5:0];
         end
      end
      top_trap = 3'h0;
      trap_any = 1'b0;
      for (arb_i = 0; arb_i < 8; arb_i = arb_i + 1) begin
         if (trap_pend_r[arb_i] && !trap_act_r[arb_i] &&
             ({1'b1, arb_i[2:0]} > cpu_priority_level_r || !cpu_priority_level_r[3])) begin
            trap_any = 1'b1;
            top_trap = arb_i[2:0];
         end
      end
   end

   assign trap_level_msb = cpu_priority_level_r[3];

   ////////////////////////////////////////////////////////////////////////////
   // core request outputs
   always @(posedge mclk) begin
      if (reset) begin
         irq_req <= 1'b0;
         irq_vector <= 6'h00;
         irq_level <= 4'h0;
      end else if (trap_any) begin
         irq_req <= 1'b1;
         irq_vector <= {3'h0, top_trap};
         irq_level <= `ITPA_TRAP_BASE | {1'b0, top_trap};
      end else if (win_any && {1'b0, win_lvl} > cpu_priority_level_r &&
                   !(nesting_disable_r && state_r == ST_SERV)) begin
         irq_req <= 1'b1;
         irq_vector <= win_src + `ITPA_VEC_BASE;
         irq_level <= {1'b0, win_lvl};
      end else begin
         irq_req <= 1'b0;
         irq_vector <= 6'h00;
         irq_level <= 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // synchroniser for asynchronous brown-out sense
   always @(posedge mclk) begin
      sync1_r <= brownout_reset;
      sync2_r <= sync1_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // trap capture, service tracking and reset causes
   always @(posedge mclk) begin
      if (reset) begin
         trap_pend_r <= 8'h00;
         trap_act_r <= 8'h00;
         state_r <= ST_RUN;
         device_reset_req <= 1'b0;
         rst_cause_r <= 3'h0;
         reset_pc <= `ITPA_RESET_PC;
      end else begin
         device_reset_req <= 1'b0;
         // invalid vector is address error
         // several traps at once are left to the lockout reset below
         if (instr_done && !trap_flushed && popcnt8(trap_event) < 4'h2) begin
            trap_pend_r <= trap_pend_r | trap_event | {3'h0, vector_invalid, 4'h0};
         end
         if ((instr_done && popcnt8(trap_event) > 4'h1) || wdt_timeout || uninit_ptr ||
             (illegal_opcode && !trap_flushed) || sync2_r) begin
            device_reset_req <= 1'b1;
            rst_cause_r <= {wdt_timeout | sync2_r, uninit_ptr, illegal_opcode};
         end
         if (irq_ack && irq_req) begin
            if (irq_level[3]) begin
               trap_act_r[irq_level[2:0]] <= 1'b1;
               trap_pend_r[irq_level[2:0]] <= 1'b0;
            end
            state_r <= ST_SERV;
         end else if (irq_return) begin
            trap_act_r <= 8'h00;
            state_r <= ST_RUN;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers and flags
   always @(posedge mclk) begin
      if (reset) begin
         request_flag_regs_r <= {NSRC{1'b0}};
         request_enable_regs_r <= {NSRC{1'b0}};
         source_priority_field_r <= {NSRC{`ITPA_PRIO_RESET}};
         nesting_disable_r <= 1'b0;
         cpu_priority_level_r <= `ITPA_CPUPL_RESET;
      end else begin
         if (reg_wr && reg_addr <= `ITPA_OFS_FLAG3) begin
            for (i = 0; i < 16; i = i + 1) begin
               if (reg_addr * 16 + i < NSRC && !reg_wdata[i]) begin
                  request_flag_regs_r[reg_addr * 16 + i] <= 1'b0;
               end
            end
         end else if (reg_wr && reg_addr >= `ITPA_OFS_EN0 && reg_addr <= `ITPA_OFS_EN3) begin
            for (i = 0; i < 16; i = i + 1) begin
               if ((reg_addr - `ITPA_OFS_EN0) * 16 + i < NSRC) begin
                  request_enable_regs_r[(reg_addr - `ITPA_OFS_EN0) * 16 + i] <= reg_wdata[i];
               end
            end
         end else if (reg_wr && reg_addr >= `ITPA_OFS_PRIO0 && reg_addr <= `ITPA_OFS_PRIO13) begin
            for (i = 0; i < 4; i = i + 1) begin
               if ((reg_addr - `ITPA_OFS_PRIO0) * 4 + i < NSRC) begin
                  source_priority_field_r[3 * ((reg_addr - `ITPA_OFS_PRIO0) * 4 + i) +: 3] <=
                     reg_wdata[4*i +: 3];
               end
            end
         end else if (reg_wr && reg_addr == `ITPA_OFS_CTRL) begin
            nesting_disable_r <= reg_wdata[`ITPA_CTRL_NEST_DIS];
         end else if (reg_wr && reg_addr == `ITPA_OFS_CPUPL && !nesting_disable_r) begin
            cpu_priority_level_r <= {cpu_priority_level_r[3], reg_wdata[2:0]};
         end
         // level follows what the core takes
         if (irq_ack && irq_req) begin
            cpu_priority_level_r <= irq_level;
         end else if (irq_return) begin
            cpu_priority_level_r <= `ITPA_CPUPL_RESET;
         end
         request_flag_regs_r <= (reg_wr && reg_addr <= `ITPA_OFS_FLAG3) ?
            (clr_mask(request_flag_regs_r, reg_addr, reg_wdata) | req_in) : (request_flag_regs_r | req_in);
      end
   end

   // flags after a software clear write
   function [NSRC-1:0] clr_mask;
      input [NSRC-1:0] f;
      input [`ITPA_ADDR_W-1:0] a;
      input [15:0] d;
      integer k;
      begin
         clr_mask = f;
         for (k = 0; k < NSRC; k = k + 1) begin
            if (k / 16 == a && !d[k % 16]) begin
               clr_mask[k] = 1'b0;
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // read data, one cycle after strobe
   always @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         reg_rdata <= 16'h0000;
         if (reg_addr <= `ITPA_OFS_FLAG3) begin
            for (rd_i = 0; rd_i < 16; rd_i = rd_i + 1) begin
               if (reg_addr * 16 + rd_i < NSRC) reg_rdata[rd_i] <= request_flag_regs_r[reg_addr * 16 + rd_i];
            end
         end else if (reg_addr >= `ITPA_OFS_EN0 && reg_addr <= `ITPA_OFS_EN3) begin
            for (rd_i = 0; rd_i < 16; rd_i = rd_i + 1) begin
               if ((reg_addr - `ITPA_OFS_EN0) * 16 + rd_i < NSRC) begin
                  reg_rdata[rd_i] <= request_enable_regs_r[(reg_addr - `ITPA_OFS_EN0) * 16 + rd_i];
               end
            end
         end else if (reg_addr >= `ITPA_OFS_PRIO0 && reg_addr <= `ITPA_OFS_PRIO13) begin
            for (rd_i = 0; rd_i < 4; rd_i = rd_i + 1) begin
               if ((reg_addr - `ITPA_OFS_PRIO0) * 4 + rd_i < NSRC) begin
                  reg_rdata[4*rd_i +: 4] <= {1'b0,
                     source_priority_field_r[3 * ((reg_addr - `ITPA_OFS_PRIO0) * 4 + rd_i) +: 3]};
               end
            end
         end else if (reg_addr == `ITPA_OFS_CTRL) begin
            reg_rdata[`ITPA_CTRL_NEST_DIS] <= nesting_disable_r;
         end else if (reg_addr == `ITPA_OFS_CPUPL) begin
            reg_rdata[3:0] <= cpu_priority_level_r;
         end else if (reg_addr == `ITPA_OFS_WIN) begin
            reg_rdata <= {win_any, 6'h00, win_lvl, win_src};
         end else if (reg_addr == `ITPA_OFS_RST) begin
            reg_rdata <= {state_r, 11'h000, rst_cause_r};
         end
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

endmodule // itpa_arbiter

// *** itpa_defs.vh ***
`ifndef ITPA_DEFS_VH
`define ITPA_DEFS_VH
// register word offsets (word address on the plain register port)
`define ITPA_ADDR_W 6
`define ITPA_OFS_FLAG0 6'h00
`define ITPA_OFS_FLAG3 6'h03
`define ITPA_OFS_EN0 6'h04
`define ITPA_OFS_EN3 6'h07
`define ITPA_OFS_PRIO0 6'h08
`define ITPA_OFS_PRIO13 6'h15
`define ITPA_OFS_CTRL 6'h18
`define ITPA_OFS_CPUPL 6'h19
`define ITPA_OFS_WIN 6'h1a
`define ITPA_OFS_RST 6'h1b
// field positions
`define ITPA_CTRL_NEST_DIS 15
`define ITPA_NIB_PRIO_MSB 2
// reset values
`define ITPA_PRIO_RESET 3'h4
`define ITPA_CPUPL_RESET 4'h0
`define ITPA_RESET_PC 24'h000000
// source layout
`define ITPA_NSRC 54
`define ITPA_VEC_BASE 6'h08
`define ITPA_SRC_EXT0 0
`define ITPA_SRC_EXT1 16
`define ITPA_SRC_EXT2 23
`define ITPA_SRC_EXT3 36
`define ITPA_SRC_EXT4 37
`define ITPA_SRC_PWM 39
`define ITPA_SRC_QEI 40
`define ITPA_SRC_RSVD 41
`define ITPA_SRC_LVD 42
`define ITPA_SRC_PWM_FAULT_A 43
`define ITPA_SRC_PWM_FAULT_B 44
`define ITPA_SRC_RSVD_LO 45
// trap levels
`define ITPA_TRAP_BASE 4'h8
`define ITPA_LVL_ALLMASK 4'h7
`endif

// *** itpa_monitor.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// port checker for the trap and interrupt arbiter
module itpa_monitor (
   // clock and reset
   input wire mclk,
   input wire reset,
   // register port
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   // trap and reset causes
   input wire [7:0] trap_event,
   input wire trap_flushed,
   input wire instr_done,
   input wire wdt_timeout,
   // core side
   input wire irq_req,
   input wire [5:0] irq_vector,
   input wire [3:0] irq_level,
   input wire device_reset_req,
   input wire [23:0] reset_pc
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // one trap, or several, at a completed instruction
   sequence s_one;
      instr_done && !trap_flushed && $onehot(trap_event);
   endsequence
   sequence s_many;
      instr_done && !trap_flushed && $countones(trap_event) > 1;
   endsequence
   // reset request is a single-cycle pulse
   sequence s_pulse;
      ##1 device_reset_req ##1 !device_reset_req;
   endsequence
   property p_rdz; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
   a_rdz: assert property (p_rdz) else $error("read data outside read slot");
   property p_vec; irq_req && !irq_level[3] |-> irq_vector >= 6'h08 && irq_vector <= 6'h34 && irq_vector != 6'h31;
   endproperty
   a_vec: assert property (p_vec) else $error("interrupt vector out of map");
   property p_trapv; irq_req && irq_level[3] |-> irq_vector == {3'h0, irq_level[2:0]}; endproperty
   a_trapv: assert property (p_trapv) else $error("trap vector and level disagree");
   property p_lvl0; irq_req |-> irq_level != 4'h0; endproperty
   a_lvl0: assert property (p_lvl0) else $error("level zero request presented");
   property p_pc; reset_pc == 24'h000000; endproperty
   a_pc: assert property (p_pc) else $error("restart address not zero");
   property p_lock; s_many |-> s_pulse; endproperty
   a_lock: assert property (p_lock) else $error("trap lockout gave no reset pulse");
   property p_wdt; wdt_timeout |-> s_pulse; endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog gave no reset pulse");
   property p_trap; s_one |-> ##[1:3] (irq_req && irq_level[3]); endproperty
   a_trap: assert property (p_trap) else $error("trap not presented");
endmodule // itpa_monitor
bind itpa_arbiter itpa_monitor mon (.mclk(mclk), .reset(reset), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .trap_event(trap_event), .trap_flushed(trap_flushed), .instr_done(instr_done), .wdt_timeout(wdt_timeout),
   .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level), .device_reset_req(device_reset_req),
   .reset_pc(reset_pc));

// *** itpa_core_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// processor core: takes presented requests late, returns on command
module itpa_core_model #(
   parameter LAT = 4
) (
   // clock and reset
   input wire mclk,
   input wire reset,
   // arbiter side
   input wire irq_req,
   input wire go,
   input wire fin,
   output reg irq_ack = 1'b0,
   output reg irq_return = 1'b0
);
   reg [3:0] wait_r = 4'h0;
   // acknowledge after LAT cycles of a standing request
   always @(posedge mclk) begin
      if (reset || !(irq_req && go)) begin
         wait_r <= 4'h0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= (wait_r == LAT - 1);
         wait_r <= (wait_r == LAT - 1) ? 4'h0 : wait_r + 4'h1;
      end
   end
   always @(posedge mclk) begin
      irq_return <= fin && !reset;
   end
endmodule // itpa_core_model

// *** tb_top.sv ***
`timescale 1ns/1ps
`include "itpa_defs.vh"
`define CHK(n,e,g) begin checked++; if ((g)!==(e)) begin num_errors++; $display("unexpected %s exp %h got %h",n,e,g); end end
module tb_top;
   reg mclk = 1'b0;
   reg reset = 1'b1;
   reg [5:0] a = 6'h00;
   reg [15:0] wd = 16'h0000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [53:0] pe = 54'h0;
   reg [9:0] pin = 10'h000;
   reg [7:0] te = 8'h00;
   reg [4:0] rc = 5'h00;
   reg idn = 1'b0;
   reg vi = 1'b0;
   reg go = 1'b0;
   reg fin = 1'b0;
   wire [15:0] rdata;
   wire [5:0] vec;
   wire [3:0] lvl;
   wire [23:0] pc;
   wire req, msb, rreq, ack, ret;
   integer num_errors = 0;
   integer checked = 0;
   integer j;
   int srcs[10] = '{0, 16, 23, 36, 37, 43, 44, 39, 40, 42};
   always #25 mclk = ~mclk;
   ////////////////////////////////////////
   itpa_arbiter uut (.mclk(mclk), .reset(reset), .reg_addr(a), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd),
      .reg_rdata(rdata), .periph_event(pe), .ext_request_0(pin[0]), .ext_request_1(pin[1]),
      .ext_request_2(pin[2]), .ext_request_3(pin[3]), .ext_request_4(pin[4]), .pwm_fault_a(pin[5]),
      .pwm_fault_b(pin[6]), .pwm_period_irq(pin[7]), .quadrature_encoder_irq(pin[8]),
      .low_voltage_detect_irq(pin[9]), .trap_event(te), .trap_flushed(rc[4]), .instr_done(idn),
      .vector_invalid(vi), .wdt_timeout(rc[0]), .uninit_ptr(rc[1]), .illegal_opcode(rc[2]),
      .brownout_reset(rc[3]), .irq_ack(ack), .irq_return(ret), .irq_req(req), .irq_vector(vec),
      .irq_level(lvl), .trap_level_msb(msb), .device_reset_req(rreq), .reset_pc(pc));
   itpa_core_model core (.mclk(mclk), .reset(reset), .irq_req(req), .go(go), .fin(fin), .irq_ack(ack),
      .irq_return(ret));
   ////////////////////////////////////////
   // register write, one strobe cycle then a gap
   task wrr(input [5:0] ad, input [15:0] d);
      begin
         a <= ad;
         wd <= d;
         wr <= 1'b1;
         @(posedge mclk);
         wr <= 1'b0;
         @(posedge mclk);
      end
   endtask
   // register read, data taken in the following cycle
   task rdc(input [5:0] ad, input [15:0] e);
      begin
         a <= ad;
         rd <= 1'b1;
         @(posedge mclk);
         rd <= 1'b0;
         #1;
         `CHK("reg_rdata", e, rdata)
         @(posedge mclk);
      end
   endtask
   // one-cycle request pulse on sources, pins and traps
   task pulse(input [53:0] p, input [9:0] n, input [7:0] t, input v);
      begin
         pe <= p;
         pin <= n;
         te <= t;
         vi <= v;
         idn <= 1'b1;
         @(posedge mclk);
         pe <= 54'h0;
         pin <= 10'h000;
         te <= 8'h00;
         vi <= 1'b0;
         idn <= 1'b0;
      end
   endtask
   // presented request after it has settled
   task ci(input r, input [5:0] v, input [3:0] l);
      begin
         repeat (2) @(posedge mclk);
         #1;
         `CHK("irq_req", r, req)
         if (r) begin
            `CHK("irq_vector", v, vec)
            `CHK("irq_level", l, lvl)
         end
         @(posedge mclk);
      end
   endtask
   // reset cause pulse, reset request looked for over five cycles
   task cause(input [4:0] c, input [7:0] t, input e);
      reg s;
      begin
         s = 1'b0;
         rc <= c;
         te <= t;
         idn <= 1'b1;
         @(posedge mclk);
         rc <= 5'h00;
         te <= 8'h00;
         idn <= 1'b0;
         // the pulse stands in the cycle right after the cause edge, two cycles later for the synchronised brown-out
         repeat (5) begin
            #1 s = s | rreq;
            @(posedge mclk);
         end
         `CHK("device_reset_req", e, s)
         @(posedge mclk);
      end
   endtask
   task give_verdict;
      begin
         if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
         else $display("RESULT: FAIL");
         $finish;
      end
   endtask
   ////////////////////////////////////////
   // main sequence
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      rdc(`ITPA_OFS_PRIO0, 16'h4444);
      `CHK("reset_pc", 24'h000000, pc)
      wrr(`ITPA_OFS_PRIO0, 16'hffff);
      rdc(`ITPA_OFS_PRIO0, 16'h7777);
      for (j = 8; j < 22; j++) wrr(6'(j), 16'h0000);
      for (j = 4; j < 8; j++) wrr(6'(j), 16'hffff);
      pulse({54{1'b1}}, 10'h000, 8'h00, 1'b0);
      ci(1'b0, 6'h00, 4'h0);
      rdc(`ITPA_OFS_FLAG0, 16'hfffe);
      rdc(6'h01, 16'hff7e);
      rdc(6'h02, 16'h004f);
      wrr(6'h09, 16'h0030);
      ci(1'b1, 6'd13, 4'd3);
      wrr(6'h09, 16'h0033);
      ci(1'b1, 6'd12, 4'd3);
      wrr(6'h09, 16'h0533);
      ci(1'b1, 6'd14, 4'd5);
      wrr(`ITPA_OFS_CPUPL, 16'h0005);
      ci(1'b0, 6'h00, 4'h0);
      wrr(`ITPA_OFS_CPUPL, 16'h0004);
      ci(1'b1, 6'd14, 4'd5);
      wrr(`ITPA_OFS_CTRL, 16'h8000);
      wrr(`ITPA_OFS_CPUPL, 16'h0007);
      ci(1'b1, 6'd14, 4'd5);
      wrr(`ITPA_OFS_CTRL, 16'h0000);
      wrr(`ITPA_OFS_CPUPL, 16'h0007);
      ci(1'b0, 6'h00, 4'h0);
      for (j = 0; j < 4; j++) wrr(6'(j), 16'h0000);
      for (j = 8; j < 22; j++) wrr(6'(j), 16'h1111);
      wrr(`ITPA_OFS_CPUPL, 16'h0000);
      for (j = 0; j < 10; j++) begin
         pulse(54'h0, 10'h001 << j, 8'h00, 1'b0);
         ci(1'b1, 6'(srcs[j] + 8), 4'd1);
         wrr(6'(srcs[j] / 16), 16'h0000);
      end
      wrr(`ITPA_OFS_CPUPL, 16'h0007);
      go <= 1'b1;
      pulse(54'h0, 10'h000, 8'h08, 1'b0);
      ci(1'b1, 6'd3, 4'd11);
      repeat (8) @(posedge mclk);
      #1;
      `CHK("trap_level_msb", 1'b1, msb)
      @(posedge mclk);
      pulse(54'h0, 10'h000, 8'h00, 1'b1);
      ci(1'b1, 6'd4, 4'd12);
      repeat (8) @(posedge mclk);
      fin <= 1'b1;
      @(posedge mclk);
      fin <= 1'b0;
      go <= 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      `CHK("trap_level_msb", 1'b0, msb)
      @(posedge mclk);
      // trap seen without a completed instruction is not taken
      te <= 8'h01;
      @(posedge mclk);
      te <= 8'h00;
      ci(1'b0, 6'h00, 4'h0);
      for (j = 0; j < 4; j++) cause(5'h01 << j, 8'h00, 1'b1);
      cause(5'h14, 8'h00, 1'b0);
      cause(5'h00, 8'h03, 1'b1);
      ci(1'b0, 6'h00, 4'h0);
      give_verdict;
   end
   // hang guard
   initial begin
      #200000;
      num_errors++;
      give_verdict;
   end
endmodule // tb_top
